// *** rtl/drive_cmd_pkg.sv ***
// Package with offsets, field positions and reset values of the drive command block.
`default_nettype none

package drive_cmd_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_CONFIG   = 8'h04;
  localparam logic [7:0] OFS_ACTIVE   = 8'h08;
  localparam logic [7:0] OFS_STATE    = 8'h0c;
  localparam logic [7:0] OFS_DECODED  = 8'h10;
  localparam logic [7:0] OFS_COUNTS   = 8'h14;

  // Command word field positions.
  localparam int CMD_PRESET_LO = 0;
  localparam int CMD_DC_BRAKE  = 2;
  localparam int CMD_COAST     = 3;
  localparam int CMD_QSTOP     = 4;
  localparam int CMD_HOLD      = 5;
  localparam int CMD_RAMPSTART = 6;
  localparam int CMD_RESET     = 7;
  localparam int CMD_JOG       = 8;
  localparam int CMD_RAMP2     = 9;
  localparam int CMD_VALID     = 10;
  localparam int CMD_RELAY1    = 11;
  localparam int CMD_RELAY4    = 12;
  localparam int CMD_SETUP_LO  = 13;
  localparam int CMD_REVERSE   = 15;

  // Configuration register field positions.
  localparam int CFG_RELAY1_LO = 0;
  localparam int CFG_RELAY4_LO = 8;
  localparam int CFG_MULTI     = 16;
  localparam int CFG_REVSRC_LO = 18;

  // Relay function selection codes that follow the command word.
  localparam logic [5:0] RELAY_FOLLOW_BIT11 = 6'h24;
  localparam logic [5:0] RELAY_FOLLOW_BIT12 = 6'h25;

  // Reversing source codes.
  localparam logic [1:0] REVSRC_DIGITAL = 2'h0;
  localparam logic [1:0] REVSRC_SERIAL  = 2'h1;
  localparam logic [1:0] REVSRC_AND     = 2'h2;
  localparam logic [1:0] REVSRC_OR      = 2'h3;

  // Reset values.
  localparam logic [15:0] CMD_RESET_VALUE    = 16'h0000;
  localparam logic [19:0] CONFIG_RESET_VALUE = 20'h00000;
  localparam logic [15:0] STATE_RESET_VALUE  = 16'h0000;
  localparam logic [15:0] COUNT_RESET_VALUE  = 16'h0000;

endpackage : drive_cmd_pkg

`default_nettype wire

// *** rtl/drive_command_status_words.sv ***
// Command word decoder and status word builder with an AHB-Lite register slave.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`default_nettype none

// How it works
// (R01) Command bits 1:0 index one of four preset references.
// (R02) Command bit 2 low requests DC braking then stop; high allows ramping.
// (R03) Command bit 3 low disables the output stage at once; motor coasts.
// (R04) Command bit 4 low requests a quick stop on the quick-stop ramp.
// (R05) Command bit 5 low freezes the present output frequency.
// (R06) While frozen, only coast, DC brake or digital stop inputs may stop.
// (R07) Command bit 6 low ramps down to stop; high permits start.
// (R08) Trip reset fires only on a rising edge of command bit 7.
// (R09) Command bit 8 high selects the jog speed as target.
// (R10) Command bit 9 selects ramp set 1 (low) or ramp set 2 (high).
// (R11) A command word with bit 10 low is ignored entirely.
// (R12) Bits 11 and 12 drive relays 01 and 04 when configured codes 36, 37.
// (R13) Bits 14:13 select set-up 1 to 4, only in multi set-up mode.
// (R14) Bit 15 reverses only when reversing source is serial, OR or AND.
// (R15) Status bit 0 shows controls ready with no trip active; bits 1, 2 show drive ready, motor enable.
// (R16) Status bits 3, 4, 6 flag trip, error, locked trip; bit 5 unused.
// (R17) Status bit 7 flags a warning; bit 8 speed equals reference.
// (R18) Status bit 9 low when local; bus commands are then refused.
// (R19) Status bit 10 high while output frequency is inside both limits.
// (R20) Status bit 11 high on start signal or nonzero output frequency.
// (R21) Status bits 12 to 15 flag overtemp, DC link, current and thermal timer.
// (R22) Lost link or internal fault forces the whole status word to zero.
// (R23) Status bit 5 is always zero; an accepted word registers in one cycle.

module drive_command_status_words (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Drive state from the control core.
  input  wire logic        controlReady,
  input  wire logic        driveReady,
  input  wire logic        motorEnabled,
  input  wire logic        tripActive,
  input  wire logic        errorNoTrip,
  input  wire logic        tripLocked,
  input  wire logic        warningActive,
  input  wire logic        speedAtReference,
  input  wire logic        localStopReset,
  input  wire logic        referenceSiteLocal,
  input  wire logic        atLowSpeedLimit,
  input  wire logic        atHighSpeedLimit,
  input  wire logic        startSignal,
  input  wire logic        outputFreqNonzero,
  input  wire logic        overTempAutoRestart,
  input  wire logic        dcLinkOutOfRange,
  input  wire logic        currentLimitExceeded,
  input  wire logic        thermalTimerOver,
  input  wire logic        linkLost,
  input  wire logic        internalCommFault,
  // Digital input functions from the terminal logic.
  input  wire logic        diDcBrake,
  input  wire logic        diCoast,
  input  wire logic        diResetCoast,
  input  wire logic        diReverse,
  // Decoded commands.
  output logic [1:0]       presetSelect,
  output logic             dcBrakeRequest,
  output logic             coastRequest,
  output logic             quickStopRequest,
  output logic             frequencyHold,
  output logic             rampStopRequest,
  output logic             tripResetPulse,
  output logic             jogSelect,
  output logic             rampSet2,
  output logic             relay01,
  output logic             relay04,
  output logic [1:0]       setupSelect,
  output logic             reverseRequest,
  output logic             digitalStopRequest,
  // Status word to the master.
  output logic [15:0]      drive_state_word
);

  // Relay follows its command bit only when its function code matches.
  function automatic logic relayDrive(input logic [5:0] code, input logic [5:0] want, input logic cmdBit);
    relayDrive = (code == want) && cmdBit;
  endfunction : relayDrive

  // Address phase capture.
  logic       dataPhase;
  logic       dataWrite;
  logic [7:0] dataAddr;

  // Software visible state.
  logic [15:0] activeWord;
  logic [19:0] configWord;
  logic [15:0] acceptCount;
  logic [15:0] ignoreCount;

  wire        addrTaken     = hsel && htrans[1] && hready;
  wire        wordSize      = (hsize == 3'h2);
  wire [7:0]  addrOffset    = haddr[7:0];
  wire        addrUpper     = (haddr[31:8] == 24'h000000);

  wire        writeCmd      = dataPhase && dataWrite && (dataAddr == drive_cmd_pkg::OFS_CMD);
  wire        writeConfig   = dataPhase && dataWrite && (dataAddr == drive_cmd_pkg::OFS_CONFIG);
  wire        writeCounts   = dataPhase && dataWrite && (dataAddr == drive_cmd_pkg::OFS_COUNTS);

  // Bus control is refused while local stop/reset or a local reference site holds.
  wire        busControlOk  = !(localStopReset || referenceSiteLocal);  // see (R18)
  wire [15:0] incomingWord  = hwdata[15:0];
  wire        wordValid     = incomingWord[drive_cmd_pkg::CMD_VALID];  // see (R11)
  wire        acceptWord    = writeCmd && wordValid && busControlOk;  // see (R11)
  wire        ignoreWord    = writeCmd && !acceptWord;

  // The new word takes effect on the very edge that stores it.
  wire [15:0] next_active   = acceptWord ? incomingWord : activeWord;  // see (R23)

  // Configuration fields.
  wire [5:0]  relay1Code    = configWord[drive_cmd_pkg::CFG_RELAY1_LO +: 6];
  wire [5:0]  relay4Code    = configWord[drive_cmd_pkg::CFG_RELAY4_LO +: 6];
  wire        multiSetup    = configWord[drive_cmd_pkg::CFG_MULTI];
  wire [1:0]  reverseSource = configWord[drive_cmd_pkg::CFG_REVSRC_LO +: 2];

  // Command decode from the next accepted word.
  wire [1:0]  next_preset   = next_active[drive_cmd_pkg::CMD_PRESET_LO +: 2];  // see (R01)
  wire        next_dcBrake  = !next_active[drive_cmd_pkg::CMD_DC_BRAKE];  // see (R02)
  wire        next_coast    = !next_active[drive_cmd_pkg::CMD_COAST];  // see (R03)
  wire        next_hold     = !next_active[drive_cmd_pkg::CMD_HOLD];  // see (R05)
  // Ramped stops are blocked while the frequency is frozen.
  wire        next_qstop    = !next_active[drive_cmd_pkg::CMD_QSTOP] && !next_hold;  // see (R04) see (R06)
  wire        next_rampStop = !next_active[drive_cmd_pkg::CMD_RAMPSTART] && !next_hold;  // see (R07) see (R06)
  wire        next_diStop   = diDcBrake || diCoast || diResetCoast;  // see (R06)
  wire        resetEdge     = acceptWord && incomingWord[drive_cmd_pkg::CMD_RESET]
                              && !activeWord[drive_cmd_pkg::CMD_RESET];  // see (R08)
  wire        next_jog      = next_active[drive_cmd_pkg::CMD_JOG];  // see (R09)
  wire        next_ramp2    = next_active[drive_cmd_pkg::CMD_RAMP2];  // see (R10)
  wire        next_relay01  = relayDrive(relay1Code, drive_cmd_pkg::RELAY_FOLLOW_BIT11,
                                         next_active[drive_cmd_pkg::CMD_RELAY1]);  // see (R12)
  wire        next_relay04  = relayDrive(relay4Code, drive_cmd_pkg::RELAY_FOLLOW_BIT12,
                                         next_active[drive_cmd_pkg::CMD_RELAY4]);  // see (R12)
  wire [1:0]  next_setup    = multiSetup ? next_active[drive_cmd_pkg::CMD_SETUP_LO +: 2] : 2'h0;  // see (R13)

  wire        cmdReverse    = next_active[drive_cmd_pkg::CMD_REVERSE];
  logic       next_reverse;
  always_comb begin
    case (reverseSource)  // see (R14)
      drive_cmd_pkg::REVSRC_DIGITAL: next_reverse = diReverse;
      drive_cmd_pkg::REVSRC_SERIAL:  next_reverse = cmdReverse;
      drive_cmd_pkg::REVSRC_AND:     next_reverse = cmdReverse && diReverse;
      drive_cmd_pkg::REVSRC_OR:      next_reverse = cmdReverse || diReverse;
      default:                       next_reverse = diReverse;
    endcase
  end

  // Status word assembly.
  wire        insideLimits  = !(atLowSpeedLimit || atHighSpeedLimit);  // see (R19)
  wire        inOperation   = startSignal || outputFreqNonzero;  // see (R20)
  wire        statusBlocked = linkLost || internalCommFault;  // see (R22)
  wire [15:0] rawStatus     = {thermalTimerOver,  // see (R21)
                               currentLimitExceeded,
                               dcLinkOutOfRange,
                               overTempAutoRestart,
                               inOperation,
                               insideLimits,
                               busControlOk,  // see (R18)
                               speedAtReference,  // see (R17)
                               warningActive,  // see (R17)
                               tripLocked,  // see (R16)
                               1'b0,  // see (R23) see (R16)
                               errorNoTrip,
                               tripActive,
                               motorEnabled,  // see (R15)
                               driveReady,
                               controlReady && !tripActive};  // see (R15)
  wire [15:0] next_state    = statusBlocked ? 16'h0000 : rawStatus;  // see (R22)

  // Read multiplexer, sampled in the address phase.
  wire [31:0] decodedView   = {16'h0000,
                               digitalStopRequest, reverseRequest, setupSelect,
                               relay04, relay01, rampSet2, jogSelect,
                               tripResetPulse, rampStopRequest, frequencyHold, quickStopRequest,
                               coastRequest, dcBrakeRequest, presetSelect};
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    if (addrTaken && !hwrite && wordSize && addrUpper) begin
      case (addrOffset)
        drive_cmd_pkg::OFS_CMD:     next_rdata = {16'h0000, activeWord};
        drive_cmd_pkg::OFS_CONFIG:  next_rdata = {12'h000, configWord};
        drive_cmd_pkg::OFS_ACTIVE:  next_rdata = {16'h0000, activeWord};
        drive_cmd_pkg::OFS_STATE:   next_rdata = {16'h0000, drive_state_word};
        drive_cmd_pkg::OFS_DECODED: next_rdata = decodedView;
        drive_cmd_pkg::OFS_COUNTS:  next_rdata = {ignoreCount, acceptCount};
        default:                    next_rdata = 32'h00000000;
      endcase
    end
  end

  // Bus slave: zero wait states, always OKAY.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dataPhase <= addrTaken && wordSize && addrUpper;
      dataWrite <= hwrite;
      dataAddr  <= addrOffset;
      hrdata    <= next_rdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software registers and word counters.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      activeWord <= drive_cmd_pkg::CMD_RESET_VALUE;
    end else begin
      activeWord <= next_active;  // see (R23)
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      configWord <= drive_cmd_pkg::CONFIG_RESET_VALUE;
    end else if (writeConfig) begin
      configWord <= hwdata[19:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acceptCount <= drive_cmd_pkg::COUNT_RESET_VALUE;
      ignoreCount <= drive_cmd_pkg::COUNT_RESET_VALUE;
    end else if (writeCounts) begin
      acceptCount <= drive_cmd_pkg::COUNT_RESET_VALUE;
      ignoreCount <= drive_cmd_pkg::COUNT_RESET_VALUE;
    end else begin
      acceptCount <= acceptCount + {15'h0, acceptWord};
      ignoreCount <= ignoreCount + {15'h0, ignoreWord};
    end
  end

  // Decoded command outputs.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      presetSelect <= 2'h0;
    end else begin
      presetSelect <= next_preset;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dcBrakeRequest <= 1'b1;
    end else begin
      dcBrakeRequest <= next_dcBrake;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coastRequest <= 1'b1;
    end else begin
      coastRequest <= next_coast;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      quickStopRequest <= 1'b0;
    end else begin
      quickStopRequest <= next_qstop;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frequencyHold <= 1'b1;
    end else begin
      frequencyHold <= next_hold;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rampStopRequest <= 1'b0;
    end else begin
      rampStopRequest <= next_rampStop;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tripResetPulse <= 1'b0;
    end else begin
      tripResetPulse <= resetEdge;  // see (R08)
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      jogSelect <= 1'b0;
    end else begin
      jogSelect <= next_jog;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rampSet2 <= 1'b0;
    end else begin
      rampSet2 <= next_ramp2;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      relay01 <= 1'b0;
    end else begin
      relay01 <= next_relay01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      relay04 <= 1'b0;
    end else begin
      relay04 <= next_relay04;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      setupSelect <= 2'h0;
    end else begin
      setupSelect <= next_setup;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reverseRequest <= 1'b0;
    end else begin
      reverseRequest <= next_reverse;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      digitalStopRequest <= 1'b0;
    end else begin
      digitalStopRequest <= next_diStop;
    end
  end

  // Status word register.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_state_word <= drive_cmd_pkg::STATE_RESET_VALUE;
    end else begin
      drive_state_word <= next_state;
    end
  end

endmodule : drive_command_status_words

`default_nettype wire

// *** testbench/drive_cmd_monitor.sv ***
// Checker of the status word timing and command decoding at the drive block ports.
`default_nettype none

module drive_cmd_monitor (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Drive state inputs.
  input wire logic        controlReady,
  input wire logic        tripActive,
  input wire logic        atLowSpeedLimit,
  input wire logic        atHighSpeedLimit,
  input wire logic        linkLost,
  input wire logic        internalCommFault,
  input wire logic        diDcBrake,
  input wire logic        diCoast,
  input wire logic        diResetCoast,
  // Decoded commands and status word.
  input wire logic        frequencyHold,
  input wire logic        quickStopRequest,
  input wire logic        rampStopRequest,
  input wire logic        tripResetPulse,
  input wire logic        digitalStopRequest,
  input wire logic [15:0] drive_state_word
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  wire commOk = !(linkLost || internalCommFault);

  property p_link_zero; !commOk |=> drive_state_word == 16'h0000; endproperty
  a_link_zero: assert property (p_link_zero) else $error("state word not cleared on lost link");
  property p_unused_bit; drive_state_word[5] == 1'b0; endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("unused state bit set");
  property p_ctrl_ready; commOk |=> drive_state_word[0] == $past(controlReady && !tripActive); endproperty
  a_ctrl_ready: assert property (p_ctrl_ready) else $error("control ready bit wrong");
  property p_trip_flag; commOk |=> drive_state_word[3] == $past(tripActive); endproperty
  a_trip_flag: assert property (p_trip_flag) else $error("trip bit wrong");
  property p_limits; commOk |=> drive_state_word[10] == !$past(atLowSpeedLimit || atHighSpeedLimit); endproperty
  a_limits: assert property (p_limits) else $error("frequency limit bit wrong");
  property p_pulse; $rose(tripResetPulse) |=> !tripResetPulse [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("trip reset pulse too long");
  property p_hold_mask; frequencyHold |-> !quickStopRequest && !rampStopRequest; endproperty
  a_hold_mask: assert property (p_hold_mask) else $error("stop request passed during hold");
  property p_di_stop; 1'b1 |=> digitalStopRequest == $past(diDcBrake || diCoast || diResetCoast); endproperty
  a_di_stop: assert property (p_di_stop) else $error("digital stop request wrong");

endmodule : drive_cmd_monitor

bind drive_command_status_words drive_cmd_monitor i_mon (
  .clk_sys(clk_sys), .resetn(resetn), .controlReady(controlReady), .tripActive(tripActive),
  .atLowSpeedLimit(atLowSpeedLimit), .atHighSpeedLimit(atHighSpeedLimit), .linkLost(linkLost),
  .internalCommFault(internalCommFault), .diDcBrake(diDcBrake), .diCoast(diCoast), .diResetCoast(diResetCoast),
  .frequencyHold(frequencyHold), .quickStopRequest(quickStopRequest), .rampStopRequest(rampStopRequest),
  .tripResetPulse(tripResetPulse), .digitalStopRequest(digitalStopRequest), .drive_state_word(drive_state_word));

`default_nettype wire

// *** testbench/fieldbus_master_model.sv ***
// Fieldbus master model issuing single word transfers on the AHB-Lite port.
`default_nettype none

module fieldbus_master_model (
  // Clock.
  input  wire logic        clk_sys,
  // AHB-Lite master side.
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Released write data is inverted so a stale value is never mistaken for a fresh one.
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask : xfer

endmodule : fieldbus_master_model

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench of the drive command and status word block.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, resetn;
  logic [19:0] st, cfg;
  logic [3:0]  di;
  wire         hsel, hwrite, hreadyout, hresp;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire  [15:0] dec, drive_state_word;
  int          errCount, checked, cycles;

  fieldbus_master_model i_master (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  drive_command_status_words i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .controlReady(st[0]), .driveReady(st[1]), .motorEnabled(st[2]), .tripActive(st[3]), .errorNoTrip(st[4]),
    .tripLocked(st[5]), .warningActive(st[6]), .speedAtReference(st[7]), .localStopReset(st[8]),
    .referenceSiteLocal(st[9]), .atLowSpeedLimit(st[10]), .atHighSpeedLimit(st[11]), .startSignal(st[12]),
    .outputFreqNonzero(st[13]), .overTempAutoRestart(st[14]), .dcLinkOutOfRange(st[15]),
    .currentLimitExceeded(st[16]), .thermalTimerOver(st[17]), .linkLost(st[18]), .internalCommFault(st[19]),
    .diDcBrake(di[0]), .diCoast(di[1]), .diResetCoast(di[2]), .diReverse(di[3]),
    .presetSelect(dec[1:0]), .dcBrakeRequest(dec[2]), .coastRequest(dec[3]), .quickStopRequest(dec[4]),
    .frequencyHold(dec[5]), .rampStopRequest(dec[6]), .tripResetPulse(dec[7]), .jogSelect(dec[8]),
    .rampSet2(dec[9]), .relay01(dec[10]), .relay04(dec[11]), .setupSelect(dec[13:12]),
    .reverseRequest(dec[14]), .digitalStopRequest(dec[15]), .drive_state_word(drive_state_word));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    if (errCount == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Decoded outputs in the order of the decoded read-back register.
  function automatic logic [15:0] exp_dec(input logic [15:0] w, input logic pulse);
    logic rv;
    case (cfg[19:18])
      2'h0: rv = di[3];
      2'h1: rv = w[15];
      2'h2: rv = w[15] & di[3];
      default: rv = w[15] | di[3];
    endcase
    return {|di[2:0], rv, cfg[16] ? w[14:13] : 2'h0, w[12] & (cfg[13:8] == 6'h25), w[11] & (cfg[5:0] == 6'h24),
            w[9], w[8], pulse, ~w[6] & w[5], ~w[5], ~w[4] & w[5], ~w[3], ~w[2], w[1:0]};
  endfunction : exp_dec

  function automatic logic [15:0] exp_st(input logic [19:0] s);
    if (s[18] | s[19]) return 16'h0000;
    return {s[17:14], s[12] | s[13], ~(s[10] | s[11]), ~(s[8] | s[9]), s[7:5], 1'b0, s[4:1], s[0] & ~s[3]};
  endfunction : exp_st

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_master.xfer(1'b1, a, d, x);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    i_master.xfer(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask : rd_chk

  task automatic t_reset();
    chk({16'h0000, dec}, 32'h0000_002c);
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    rd_chk(drive_cmd_pkg::OFS_CMD, 32'h0000_0000);
    rd_chk(drive_cmd_pkg::OFS_CONFIG, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000);
  endtask : t_reset

  task automatic t_cmds();
    logic [15:0] w [4] = '{16'h0400, 16'h2f55, 16'h5e2a, 16'hff7f};
    logic [15:0] e;
    for (int k = 0; k < 4; k++) begin
      cfg = {k[1:0], 1'b0, k[1], 2'h0, k[0] ? 6'h25 : 6'h24, 2'h0, k[0] ? 6'h24 : 6'h25};
      @(posedge clk_sys);
      di[3] <= k[0];
      wr(drive_cmd_pkg::OFS_CONFIG, {12'h000, cfg});
      rd_chk(drive_cmd_pkg::OFS_CONFIG, {12'h000, cfg});
      foreach (w[j]) begin
        wr(drive_cmd_pkg::OFS_CMD, {16'h0000, w[j]});
        e = exp_dec(w[j], 1'b0);
        chk({16'h0000, dec}, {16'h0000, e});
        rd_chk(drive_cmd_pkg::OFS_ACTIVE, {16'h0000, w[j]});
        rd_chk(drive_cmd_pkg::OFS_DECODED, {16'h0000, e});
      end
    end
  endtask : t_cmds

  task automatic t_ignore();
    wr(drive_cmd_pkg::OFS_COUNTS, 32'h0000_0000);
    wr(drive_cmd_pkg::OFS_CMD, 32'h0000_fbff);
    chk({16'h0000, dec}, {16'h0000, exp_dec(16'hff7f, 1'b0)});
    @(posedge clk_sys);
    st[8] <= 1'b1;
    wr(drive_cmd_pkg::OFS_CMD, 32'h0000_0400);
    chk({16'h0000, dec}, {16'h0000, exp_dec(16'hff7f, 1'b0)});
    @(posedge clk_sys);
    st[8] <= 1'b0;
    rd_chk(drive_cmd_pkg::OFS_ACTIVE, 32'h0000_ff7f);
    rd_chk(drive_cmd_pkg::OFS_COUNTS, 32'h0002_0000);
  endtask : t_ignore

  task automatic t_trip();
    logic [15:0] sent [5] = '{16'h0480, 16'h0480, 16'h0400, 16'h0080, 16'h0480};
    logic [15:0] kept [5] = '{16'h0480, 16'h0480, 16'h0400, 16'h0400, 16'h0480};
    logic        edge1 [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    foreach (sent[j]) begin
      wr(drive_cmd_pkg::OFS_CMD, {16'h0000, sent[j]});
      chk({16'h0000, dec}, {16'h0000, exp_dec(kept[j], edge1[j])});
    end
  endtask : t_trip

  task automatic t_status();
    logic [19:0] p [12] = '{20'h00001, 20'h00009, 20'h3c0f7, 20'h00102, 20'h00204, 20'h00400,
                            20'h00800, 20'h01000, 20'h02000, 20'h4ffff, 20'h8ffff, 20'h00000};
    foreach (p[j]) begin
      @(posedge clk_sys);
      st <= p[j];
      di[2:0] <= p[j][2:0];
      @(posedge clk_sys);
      #1;
      chk({16'h0000, drive_state_word}, {16'h0000, exp_st(p[j])});
      chk({31'h0, dec[15]}, {31'h0, |p[j][2:0]});
    end
  endtask : t_status

  initial begin
    resetn = 1'b0;
    st = 20'h00000;
    cfg = 20'h00000;
    di = 4'h0;
    errCount = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_cmds();
    t_ignore();
    t_trip();
    t_status();
    tally_and_finish();
  end

endmodule : tb

`default_nettype wire
